/* File: core/fsc_flash_dev.sv */
/*
  flash device end: status and configuration register commands.
  assumes link pins are asynchronous; all of them pass two flops.
*/
// The implementer's own choices: the strobed register port and the address map.
// What this block does
// - read configuration allowed anytime, even busy
// - read configuration shifts out on serial_out
// - host polls write_in_progress before new instruction
// - config bit 7 selects hold or reset
// - hold and reset only when quad_enable 0
// - config bits 6:5 select drive strength
// - config bit 2 selects protection scheme
// - block locks set after any reset
// - config bit 1 selects dummy clock count
// - status write needs prior write enable
// - status write keeps bits 15,10,1,0
// - status write ends at 8 or 16 bits
// - one-byte status write clears three bits
// - status write runs timed busy cycle
// - hardware protected mode blocks status write
// - option variant takes one status byte only
// - code 31h only in option variant
// - config write needs enable, exact one byte
// - config write runs timed busy cycle
// - protect mode 01 with pin low locks
// - latch clear refuses all register writes
`timescale 1ns/100ps
`default_nettype none
module fsc_flash_dev
  import fsc_pkg::*;
#(
  parameter bit ORDER_OPT = 1'b0
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  fsc_link_if.dev link,
  output logic [15:0] status_out,
  output logic [7:0] config_out,
  output logic busy_out,
  output logic hold_active_out,
  output logic pin_reset_out,
  output logic [1:0] drive_strength_out,
  output logic protect_scheme_out,
  output logic [3:0] dummy_dual_out,
  output logic [3:0] dummy_quad_out,
  output logic [LOCK_N-1:0] block_lock_out
);
  // ----------------------------------------------------------------
  // pin synchronisers: cs, sclk, si, wp, hold/reset
  // ----------------------------------------------------------------
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic sclk_prev_r;
  logic cs_prev_r;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sync1_r <= 5'h1b;
      sync2_r <= 5'h1b;
      sclk_prev_r <= 1'b0;
      cs_prev_r <= 1'b1;
    end else begin
      sync1_r <= {link.hold_reset_pin, link.write_protect_pin, link.serial_in,
                  link.serial_clk, link.chip_select_n};
      sync2_r <= sync1_r;
      sclk_prev_r <= sync2_r[1];
      cs_prev_r <= sync2_r[0];
    end
  end

  // ----------------------------------------------------------------
  // register state and decode terms
  // ----------------------------------------------------------------
  logic [7:0] cfg_r;
  logic cmp_r;
  logic [2:0] lb_r;
  logic qe_r;
  logic [1:0] srp_r;
  logic [4:0] bp_r;
  logic wel_r;
  logic [13:0] tw_cnt_r;
  logic [4:0] bitcnt_r;
  logic [7:0] op_r;
  logic [15:0] data_r;
  logic [7:0] sh_r;
  logic rd_mode_r;
  logic [LOCK_N-1:0] lock_r;
  logic so_r;
  logic so_oe_n_r;
  logic busy;
  logic hold_now;
  logic pin_rst;
  logic cs_n;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_rise;
  logic locked;
  logic [7:0] op_done;
  logic [15:0] status_now;
  logic is_write_status_cmd;
  logic write_status_cmd_ok;
  logic write_config_cmd_ok;

  assign busy = (tw_cnt_r != 14'h0);
  assign cs_n = sync2_r[0];
  assign hold_now = ~qe_r & ~cfg_r[CFG_PIN_FUNC] & ~sync2_r[4];
  assign pin_rst = ~qe_r & cfg_r[CFG_PIN_FUNC] & ~sync2_r[4];
  assign sclk_rise = sync2_r[1] & ~sclk_prev_r & ~cs_n & ~hold_now;
  assign sclk_fall = ~sync2_r[1] & sclk_prev_r & ~cs_n & ~hold_now;
  assign cs_rise = cs_n & ~cs_prev_r;
  assign locked = srp_r[1] | (srp_r == 2'b01 & ~sync2_r[3]);
  assign op_done = {op_r[6:0], sync2_r[2]};
  assign status_now = {1'b0, cmp_r, lb_r, 1'b0, qe_r, srp_r[1], srp_r[0], bp_r, wel_r, busy};
  assign is_write_status_cmd = (op_r == OP_WRITE_STATUS) | (ORDER_OPT & op_r == OP_WRITE_STATUS_ALT);
  assign write_status_cmd_ok = cs_rise & is_write_status_cmd & wel_r & ~busy & ~locked &
    ((bitcnt_r == BITS_ONE_BYTE) | (~ORDER_OPT & bitcnt_r == BITS_TWO_BYTE));
  assign write_config_cmd_ok = cs_rise & (op_r == OP_WRITE_CONFIG) & wel_r & ~busy & ~locked &
    (bitcnt_r == BITS_ONE_BYTE);

  // ----------------------------------------------------------------
  // serial shifter: opcode, data in, register data out
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || pin_rst) begin
      bitcnt_r <= 5'h0;
      op_r <= 8'h0;
      data_r <= 16'h0;
      sh_r <= 8'h0;
      rd_mode_r <= 1'b0;
      so_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else if (cs_n) begin
      bitcnt_r <= 5'h0;
      rd_mode_r <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else begin
      if (hold_now) begin
        so_oe_n_r <= 1'b1;
      end
      if (sclk_rise) begin
        if (bitcnt_r != 5'h1f) begin
          bitcnt_r <= bitcnt_r + 5'h1;
        end
        if (bitcnt_r < BITS_OPCODE) begin
          op_r <= op_done;
        end else begin
          data_r <= {data_r[14:0], sync2_r[2]};
        end
        if (bitcnt_r == BITS_OPCODE - 5'h1) begin
          if (op_done == OP_READ_CONFIG) begin
            rd_mode_r <= 1'b1;
            sh_r <= cfg_r & CFG_WRITE_MASK;
          end else if (op_done == OP_READ_STATUS_LO) begin
            rd_mode_r <= 1'b1;
            sh_r <= status_now[7:0];
          end else if (op_done == OP_READ_STATUS_HI) begin
            rd_mode_r <= 1'b1;
            sh_r <= status_now[15:8];
          end
        end
      end
      if (sclk_fall && rd_mode_r) begin
        so_r <= sh_r[7];
        so_oe_n_r <= 1'b0;
        sh_r <= {sh_r[6:0], sh_r[7]};
      end
    end
  end

  // ----------------------------------------------------------------
  // status register, write enable latch, self-timed cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cmp_r <= STATUS_RESET[14];
      lb_r <= STATUS_RESET[13:11];
      qe_r <= STATUS_RESET[9];
      srp_r <= STATUS_RESET[8:7];
      bp_r <= STATUS_RESET[6:2];
      wel_r <= 1'b0;
      tw_cnt_r <= 14'h0;
    end else begin
      if (busy) begin
        tw_cnt_r <= tw_cnt_r - 14'h1;
        if (tw_cnt_r == 14'h1) begin
          wel_r <= 1'b0;
        end
      end
      if (write_status_cmd_ok || write_config_cmd_ok) begin
        tw_cnt_r <= 14'(STATUS_WRITE_CYC);
      end
      if (write_status_cmd_ok && bitcnt_r == BITS_ONE_BYTE) begin
        srp_r <= {1'b0, data_r[7]};
        bp_r <= data_r[6:2];
        cmp_r <= 1'b0;
        qe_r <= 1'b0;
      end else if (write_status_cmd_ok) begin
        srp_r <= {data_r[0], data_r[15]};
        bp_r <= data_r[14:10];
        cmp_r <= data_r[6];
        lb_r <= lb_r | data_r[5:3];
        qe_r <= data_r[1];
      end
      if (cs_rise && !busy && op_r == OP_WRITE_ENABLE && bitcnt_r == BITS_OPCODE) begin
        wel_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration register and block locks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg_r <= CFG_RESET;
      lock_r <= '1;
    end else begin
      if (pin_rst) begin
        lock_r <= '1;
        cfg_r[CFG_DUMMY_SEL] <= CFG_RESET[CFG_DUMMY_SEL];
      end else if (write_config_cmd_ok) begin
        cfg_r <= data_r[7:0] & CFG_WRITE_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      status_out <= STATUS_RESET;
      config_out <= CFG_RESET;
      busy_out <= 1'b0;
      hold_active_out <= 1'b0;
      pin_reset_out <= 1'b0;
      drive_strength_out <= {CFG_RESET[CFG_DRV_HI], CFG_RESET[CFG_DRV_LO]};
      protect_scheme_out <= CFG_RESET[CFG_PROT_SCHEME];
      dummy_dual_out <= DUMMY_DUAL_DEF;
      dummy_quad_out <= DUMMY_QUAD_DEF;
      block_lock_out <= '1;
    end else begin
      status_out <= status_now;
      config_out <= cfg_r;
      busy_out <= busy;
      hold_active_out <= hold_now;
      pin_reset_out <= pin_rst;
      drive_strength_out <= {cfg_r[CFG_DRV_HI], cfg_r[CFG_DRV_LO]};
      protect_scheme_out <= cfg_r[CFG_PROT_SCHEME];
      dummy_dual_out <= cfg_r[CFG_DUMMY_SEL] ? DUMMY_DUAL_ALT : DUMMY_DUAL_DEF;
      dummy_quad_out <= cfg_r[CFG_DUMMY_SEL] ? DUMMY_QUAD_ALT : DUMMY_QUAD_DEF;
      block_lock_out <= lock_r;
    end
  end

  assign link.serial_out = so_r;
  assign link.serial_out_oe_n = so_oe_n_r;
endmodule
`default_nettype wire

/* File: core/fsc_flash_host.sv */
/*
  flash host controller end: runs one register command per order.
  assumes software polls busy before issuing the next order.
*/
`timescale 1ns/100ps
`default_nettype none
module fsc_flash_host
  import fsc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  fsc_link_if.host link
);
  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END, H_GAP} fsc_hstate_e;
  // ----------------------------------------------------------------
  // command registers
  // ----------------------------------------------------------------
  fsc_hstate_e state_r;
  logic [15:0] tx_r;
  logic [7:0] rx_r;
  logic [1:0] pin_r;
  logic [23:0] sh_r;
  logic [4:0] nbits_r;
  logic [4:0] done_r;
  logic [3:0] div_r;
  logic sclk_r;
  logic cs_n_r;
  logic mosi_r;
  logic [1:0] miso_sync_r;
  logic start;
  logic tick;

  assign start = wr_in && addr_in == HOST_CMD_OFS && state_r == H_IDLE;
  assign tick = (div_r == 4'(SCLK_HALF_CYC - 1));

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tx_r <= 16'h0;
      pin_r <= HOST_PIN_RESET;
    end else if (wr_in) begin
      if (addr_in == HOST_TX_OFS) begin
        tx_r <= wdata_in[15:0];
      end else if (addr_in == HOST_PIN_OFS) begin
        pin_r <= wdata_in[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_out <= 32'h0;
    end else if (rd_in) begin
      if (addr_in == HOST_STAT_OFS) begin
        rdata_out <= {16'h0, rx_r, 7'h0, state_r != H_IDLE};
      end else if (addr_in == HOST_TX_OFS) begin
        rdata_out <= {16'h0, tx_r};
      end else if (addr_in == HOST_PIN_OFS) begin
        rdata_out <= {30'h0, pin_r};
      end else begin
        rdata_out <= 32'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // serial engine: divided clock, msb first
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      miso_sync_r <= 2'h0;
    end else begin
      miso_sync_r <= {miso_sync_r[0], link.serial_out};
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_r <= H_IDLE;
      sh_r <= 24'h0;
      nbits_r <= 5'h0;
      done_r <= 5'h0;
      div_r <= 4'h0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      mosi_r <= 1'b0;
      rx_r <= 8'h0;
    end else begin
      div_r <= (state_r == H_IDLE || tick) ? 4'h0 : div_r + 4'h1;
      case (state_r)
        H_IDLE: begin
          if (start) begin
            sh_r <= {wdata_in[7:0], tx_r};
            mosi_r <= wdata_in[7];
            nbits_r <= 5'(({3'h0, wdata_in[9:8]} + {4'h0, wdata_in[16]} + 5'h1) << 3);
            done_r <= 5'h0;
            cs_n_r <= 1'b0;
            state_r <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          if (tick) begin
            sclk_r <= ~sclk_r;
            if (!sclk_r) begin
              done_r <= done_r + 5'h1;
              rx_r <= {rx_r[6:0], miso_sync_r[1]};
            end else if (done_r == nbits_r) begin
              state_r <= H_END;
            end else begin
              sh_r <= {sh_r[22:0], 1'b0};
              mosi_r <= sh_r[22];
            end
          end
        end
        H_END: begin
          if (tick) begin
            cs_n_r <= 1'b1;
            state_r <= H_GAP;
          end
        end
        default: begin
          if (tick) begin
            state_r <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.chip_select_n = cs_n_r;
  assign link.serial_clk = sclk_r;
  assign link.serial_in = mosi_r;
  assign link.write_protect_pin = pin_r[0];
  assign link.hold_reset_pin = pin_r[1];
endmodule
`default_nettype wire

/* File: core/fsc_link_if.sv */
/*
  serial link between flash host controller and flash device.
  assumes the bench resolves the data-out pin from its enable.
*/
`timescale 1ns/100ps
`default_nettype none
interface fsc_link_if;
  logic chip_select_n;
  logic serial_clk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  logic write_protect_pin;
  logic hold_reset_pin;
  modport dev (
    input chip_select_n, serial_clk, serial_in, write_protect_pin, hold_reset_pin,
    output serial_out, serial_out_oe_n
  );
  modport host (
    output chip_select_n, serial_clk, serial_in, write_protect_pin, hold_reset_pin,
    input serial_out, serial_out_oe_n
  );
endinterface
`default_nettype wire

/* File: core/fsc_pkg.sv */
/*
  constants shared by both ends of the serial flash register link.
  assumes a 250 MHz system clock on both ends.
*/
package fsc_pkg;
  // ----------------------------------------------------------------
  // clocking and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int STATUS_WRITE_TIME_NS = 10000;
  localparam int STATUS_WRITE_CYC = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int SCLK_HALF_CYC = 8;
  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_READ_STATUS_LO = 8'h05;
  localparam logic [7:0] OP_READ_STATUS_HI = 8'h35;
  localparam logic [7:0] OP_READ_CONFIG = 8'h15;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_STATUS_ALT = 8'h31;
  localparam logic [7:0] OP_WRITE_CONFIG = 8'h11;
  // ----------------------------------------------------------------
  // bit counts at chip select rise (opcode plus data)
  // ----------------------------------------------------------------
  localparam logic [4:0] BITS_OPCODE = 5'h08;
  localparam logic [4:0] BITS_ONE_BYTE = 5'h10;
  localparam logic [4:0] BITS_TWO_BYTE = 5'h18;
  // ----------------------------------------------------------------
  // configuration register fields and reset values
  // ----------------------------------------------------------------
  localparam int CFG_PIN_FUNC = 7;
  localparam int CFG_DRV_HI = 6;
  localparam int CFG_DRV_LO = 5;
  localparam int CFG_PROT_SCHEME = 2;
  localparam int CFG_DUMMY_SEL = 1;
  localparam logic [7:0] CFG_WRITE_MASK = 8'he6;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // ----------------------------------------------------------------
  // dummy clock counts, block locks
  // ----------------------------------------------------------------
  localparam logic [3:0] DUMMY_DUAL_DEF = 4'h4;
  localparam logic [3:0] DUMMY_DUAL_ALT = 4'h8;
  localparam logic [3:0] DUMMY_QUAD_DEF = 4'h6;
  localparam logic [3:0] DUMMY_QUAD_ALT = 4'ha;
  localparam int LOCK_N = 8;
  // ----------------------------------------------------------------
  // host command port map
  // ----------------------------------------------------------------
  localparam logic [3:0] HOST_CMD_OFS = 4'h0;
  localparam logic [3:0] HOST_TX_OFS = 4'h4;
  localparam logic [3:0] HOST_STAT_OFS = 4'h8;
  localparam logic [3:0] HOST_PIN_OFS = 4'hc;
  localparam logic [1:0] HOST_PIN_RESET = 2'h3;
endpackage

/* File: verification/fsc_link_monitor.sv */
/*
  checker for the serial wires between host and flash device ends.
  assumes plain inputs tied to one link instance, sync active low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module fsc_link_monitor (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic chip_select_n,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n
);
  // ----------------------------------------------------------------
  // serial clock rises within a frame
  // ----------------------------------------------------------------
  logic [5:0] rise_cnt_r;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || chip_select_n) begin
      rise_cnt_r <= 6'h00;
    end else if ($rose(serial_clk)) begin
      rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  property p_sclk_idle; chip_select_n |-> !serial_clk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk moves outside frame");
  property p_sclk_half; $rose(serial_clk) |=> serial_clk [*7] ##1 !serial_clk; endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("sclk high phase wrong");
  property p_lead; $fell(chip_select_n) |-> !serial_clk [*7]; endproperty
  a_lead: assert property (p_lead) else $error("sclk too soon after select");
  property p_si_hold; $rose(serial_clk) |-> $stable(serial_in); endproperty
  a_si_hold: assert property (p_si_hold) else $error("data in moves at sclk rise");
  property p_boundary;
    $rose(chip_select_n) |-> rise_cnt_r[2:0] == 3'h0 && rise_cnt_r != 6'h00;
  endproperty
  a_boundary: assert property (p_boundary) else $error("select ends off byte");
  property p_oe_late; !serial_out_oe_n && !chip_select_n |-> rise_cnt_r >= 6'h08; endproperty
  a_oe_late: assert property (p_oe_late) else $error("data out before opcode done");
  property p_oe_release; $rose(chip_select_n) |-> ##[1:5] serial_out_oe_n; endproperty
  a_oe_release: assert property (p_oe_release) else $error("data out not released");
  property p_so_fall; !serial_out_oe_n && $changed(serial_out) |-> !serial_clk; endproperty
  a_so_fall: assert property (p_so_fall) else $error("data out moves while sclk high");
  c_two_byte: cover property ($rose(chip_select_n) && rise_cnt_r == 6'h18);
  c_one_byte: cover property ($rose(chip_select_n) && rise_cnt_r == 6'h10);
  c_read: cover property ($fell(serial_out_oe_n));
endmodule
`default_nettype wire

/* File: verification/tb_flash_status_config_reg_access.sv */
/*
  bench for two host and device pairs, plain and ordering option variant.
  assumes both hosts share one register port; model runs on integers.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_flash_status_config_reg_access
  import fsc_pkg::*;
;
  // ----------------------------------------------------------------
  // signals and model state
  // ----------------------------------------------------------------
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata [2];
  logic [15:0] st_o [2];
  logic [7:0] cf_o [2];
  logic busy_o [2];
  logic [1:0] drv_o [2];
  logic ps_o [2];
  logic [3:0] dd_o [2];
  logic [3:0] dq_o [2];
  logic [7:0] lk_o [2];
  logic hold_o [2];
  logic rst_o [2];
  logic [7:0] ops [3] = '{OP_WRITE_STATUS, OP_WRITE_STATUS_ALT, OP_WRITE_CONFIG};
  int st [2] = '{0, 0};
  int cf [2] = '{0, 0};
  int wp = 1;
  int hr = 1;
  int err_total = 0;
  int n_compared = 0;
  int seed = 32'h181806f4;
  always #2 clk_sys_in = ~clk_sys_in;
  fsc_link_if link [2] ();
  for (genvar k = 0; k < 2; k++) begin : g_end
    fsc_flash_host fsc_flash_host_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata[k]),
      .link(link[k]));
    fsc_flash_dev #(.ORDER_OPT(k == 1)) fsc_flash_dev_inst (.clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in), .link(link[k]), .status_out(st_o[k]), .config_out(cf_o[k]),
      .busy_out(busy_o[k]), .hold_active_out(hold_o[k]), .pin_reset_out(rst_o[k]),
      .drive_strength_out(drv_o[k]), .protect_scheme_out(ps_o[k]),
      .dummy_dual_out(dd_o[k]), .dummy_quad_out(dq_o[k]), .block_lock_out(lk_o[k]));
  end
  fsc_link_monitor fsc_link_monitor_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
    .chip_select_n(link[0].chip_select_n), .serial_clk(link[0].serial_clk),
    .serial_in(link[0].serial_in), .serial_out(link[0].serial_out),
    .serial_out_oe_n(link[0].serial_out_oe_n));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1;
  endtask
  task automatic wait_end(input logic dev);
    int i;
    for (i = 0; i < 4000; i++) begin
      rd_reg(HOST_STAT_OFS);
      if (rdata[0][0] === 1'b0 && rdata[1][0] === 1'b0 &&
          (!dev || (busy_o[0] === 1'b0 && busy_o[1] === 1'b0))) begin
        return;
      end
    end
    err_total++;
    close_out();
  endtask
  task automatic cmd(input logic [7:0] op, input logic [1:0] n, input logic rb,
                     input logic [15:0] d);
    wr_reg(HOST_TX_OFS, {16'h0000, d[7:0], d[15:8]});
    wr_reg(HOST_CMD_OFS, {15'h0000, rb, 6'h00, n, op});
    wait_end(1'b0);
  endtask
  task automatic chk_dev();
    int k;
    #1;
    for (k = 0; k < 2; k++) begin
      chk("hold", hold_o[k], hr == 0 && !st[k][9] && !cf[k][7]);
      chk("pinrst", rst_o[k], hr == 0 && !st[k][9] && cf[k][7]);
      chk("status", st_o[k], st[k]);
      chk("config", cf_o[k], cf[k]);
      chk("drive", drv_o[k], cf[k][6:5]);
      chk("scheme", ps_o[k], cf[k][2]);
      chk("dual", dd_o[k], cf[k][1] ? DUMMY_DUAL_ALT : DUMMY_DUAL_DEF);
      chk("quad", dq_o[k], cf[k][1] ? DUMMY_QUAD_ALT : DUMMY_QUAD_DEF);
      chk("locks", lk_o[k], 8'hff);
    end
  endtask
  task automatic op_write(input logic [7:0] op, input logic [1:0] n, input logic en,
                          input logic [15:0] d);
    int k;
    logic acc [2];
    if (en) begin
      cmd(OP_WRITE_ENABLE, 2'h0, 1'b0, 16'h0000);
      for (k = 0; k < 2; k++) begin
        st[k] = st[k] | 2;
        chk("wel", st_o[k][1], 1'b1);
      end
    end
    cmd(op, n, 1'b0, d);
    for (k = 0; k < 2; k++) begin
      acc[k] = st[k][1] && !st[k][8] && !(st[k][7] && wp == 0) &&
        (op == OP_WRITE_CONFIG ? n == 2'h1 :
         op == OP_WRITE_STATUS ? (n == 2'h1 || (n == 2'h2 && k == 0)) : (n == 2'h1 && k == 1));
      chk("busy", busy_o[k], acc[k]);
    end
    if (op != OP_WRITE_CONFIG) begin
      cmd(OP_READ_CONFIG, 2'h0, 1'b1, 16'h0000);
      for (k = 0; k < 2; k++) begin
        chk("rdcfg", rdata[k][15:8], cf[k]);
      end
    end
    for (k = 0; k < 2; k++) begin
      if (acc[k] && op == OP_WRITE_CONFIG) begin
        cf[k] = d[7:0] & CFG_WRITE_MASK;
        st[k] = st[k] & 16'hfffd;
      end else if (acc[k]) begin
        st[k] = (st[k] & 16'h3800) | (d & (n == 2'h2 ? 16'h43fc : 16'h00fc));
      end
    end
    wait_end(1'b1);
    for (k = 0; k < 2; k++) begin
      cmd(k ? OP_READ_STATUS_HI : OP_READ_STATUS_LO, 2'h0, 1'b1, 16'h0000);
      chk("rdsr0", rdata[0][15:8], k ? st[0][15:8] : st[0][7:0]);
      chk("rdsr1", rdata[1][15:8], k ? st[1][15:8] : st[1][7:0]);
    end
    chk_dev();
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    int j;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    chk_dev();
    rd_reg(4'h2);
    chk("unmapped", rdata[0], 32'h0);
    wr_reg(HOST_PIN_OFS, 32'h1);
    hr = 0;
    repeat (10) @(posedge clk_sys_in);
    chk_dev();
    wr_reg(HOST_PIN_OFS, 32'h3);
    hr = 1;
    repeat (10) @(posedge clk_sys_in);
    op_write(OP_WRITE_STATUS, 2'h2, 1'b0, 16'h0284);
    for (i = 0; i < 3; i++) begin
      for (j = 2; j >= 0; j--) begin
        op_write(ops[i], j[1:0], 1'b1, 16'($random(seed)) & 16'hc6ff);
      end
    end
    op_write(OP_WRITE_STATUS, 2'h1, 1'b1, 16'h0080);
    wp = 0;
    wr_reg(HOST_PIN_OFS, 32'h2);
    op_write(OP_WRITE_CONFIG, 2'h1, 1'b1, 16'h00ff);
    wp = 1;
    wr_reg(HOST_PIN_OFS, 32'h3);
    op_write(OP_WRITE_CONFIG, 2'h1, 1'b1, 16'h0082);
    op_write(OP_WRITE_STATUS, 2'h1, 1'b1, 16'h0000);
    wr_reg(HOST_PIN_OFS, 32'h1);
    hr = 0;
    repeat (20) @(posedge clk_sys_in);
    for (i = 0; i < 2; i++) begin
      cf[i] = cf[i] & 8'hfd;
    end
    chk_dev();
    wr_reg(HOST_PIN_OFS, 32'h3);
    hr = 1;
    repeat (10) @(posedge clk_sys_in);
    chk_dev();
    close_out();
  end
endmodule
`default_nettype wire
